/* cbs_lane.sv */
/*
 * Package of shared constants for the chip select bus sizing block,
 * plus the lane planner that decides which data lanes one beat uses.
 * Assumes a single clock domain; the planner is purely combinational.
 */
package cbs_pkg;
	// ==========================================================
	// area control byte layout
	localparam int        CTRL_W         = 8;
	localparam int        ENABLE_BIT     = 7;
	localparam int        WIDTH_BIT      = 3;
	localparam int        WAIT_LSB       = 0;
	localparam int        WAIT_W         = 3;
	localparam int        AREAS          = 4;
	localparam int        DEFAULT_AREA   = 4;
	localparam int        ENABLED_AREA   = 2;
	localparam logic [7:0] CTRL_RESET_OFF = 8'h00;
	localparam logic [7:0] CTRL_RESET_ON  = 8'h80;
	// ==========================================================
	// wait select codes
	localparam logic [2:0] WAIT_TWO      = 3'h0;
	localparam logic [2:0] WAIT_ONE      = 3'h1;
	localparam logic [2:0] WAIT_ONE_EXT  = 3'h2;
	localparam logic [2:0] WAIT_NONE     = 3'h3;
	localparam logic [2:0] WAIT_ZERO_EXT = 3'h4;
	localparam logic [2:0] WAIT_THREE    = 3'h5;
	localparam logic [2:0] WAIT_FOUR     = 3'h6;
	localparam logic [2:0] WAIT_EIGHT    = 3'h7;
	localparam logic [3:0] CNT_0         = 4'h0;
	localparam logic [3:0] CNT_1         = 4'h1;
	localparam logic [3:0] CNT_2         = 4'h2;
	localparam logic [3:0] CNT_3         = 4'h3;
	localparam logic [3:0] CNT_4         = 4'h4;
	localparam logic [3:0] CNT_8         = 4'h8;
	localparam logic [2:0] BYTES_1       = 3'h1;
	localparam logic [2:0] BYTES_2       = 3'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} cbs_state_type;

	// fixed wait count for a wait code
	function automatic logic [3:0] cbs_wait_count(input logic [2:0] code);
		case (code)
			WAIT_TWO:      cbs_wait_count = CNT_2;
			WAIT_ONE:      cbs_wait_count = CNT_1;
			WAIT_ONE_EXT:  cbs_wait_count = CNT_1;
			WAIT_THREE:    cbs_wait_count = CNT_3;
			WAIT_FOUR:     cbs_wait_count = CNT_4;
			WAIT_EIGHT:    cbs_wait_count = CNT_8;
			default:       cbs_wait_count = CNT_0;
		endcase
	endfunction
endpackage

`timescale 1ns/1ps
`default_nettype none

module cbs_lane
	import cbs_pkg::*;
(
	// beat description
	input  wire logic       bus8,
	input  wire logic       addr0,
	input  wire logic [2:0] remain,
	// lane plan
	output logic [1:0]      lane_use,
	output logic [2:0]      beat_bytes
);
	// ==========================================================
	// lane choice
	always_comb begin
		if (bus8) begin
			lane_use   = 2'h1;
			beat_bytes = BYTES_1;
		end else if (!addr0 && remain >= BYTES_2) begin
			lane_use   = 2'h3;
			beat_bytes = BYTES_2;
		end else begin
			lane_use   = addr0 ? 2'h2 : 2'h1;
			beat_bytes = BYTES_1;
		end
	end
endmodule // cbs_lane

`default_nettype wire

/* cbs_top.sv */
/*
 * Chip select and dynamic bus sizing controller: four programmable
 * areas plus a default area, byte-lane steering and wait states.
 * Assumes address decode hits and internal-resource hits come from
 * logic on CLK; WAIT_N is an asynchronous pin.
 */
// Contract
// - area settings act only while control bit 7 is one
// - reset enables area 2 only, areas 0, 1, 3 disabled
// - bit 3 of every control byte, default too, selects width
// - width bit zero means 16-bit bus, one means 8-bit bus
// - bus width per access comes from the hit area's setting
// - read data on lanes carrying no operand byte is dropped
// - write leaves unused lanes undriven
// - write strobe of an unused lane stays inactive all cycle
// - bits 2..0 choose fixed waits or wait-pin extension
// - reset sets every wait field to two fixed waits
// - addresses outside the areas use the default control byte
// - internal resource hits give no external select
`timescale 1ns/1ps
`default_nettype none

module cbs_top
	import cbs_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              RESETN,
	// control bytes
	input  wire logic [4:0]        CTRL_WE,
	input  wire logic [7:0]        CTRL_WDATA,
	output logic [39:0]            AREA_CONTROL_Q,
	// cpu request
	input  wire logic              REQ,
	input  wire logic              WRITE,
	input  wire logic [2:0]        SIZE,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        AREA_HIT,
	input  wire logic              INTERNAL_HIT,
	output logic                   ACK,
	output logic [31:0]            RDATA,
	// external bus
	output logic [ADDR_W-1:0]      EXT_ADDR,
	output logic [3:0]             AREA_SELECT_N,
	output logic                   RD_N,
	output logic                   WR_N,
	output logic                   HIGH_LANE_WRITE_STROBE_N,
	output logic [15:0]            DATA_OUT,
	output logic [1:0]             DATA_OE,
	input  wire logic [15:0]       DATA_IN,
	input  wire logic              WAIT_N
);
	cbs_state_type     state;
	logic [7:0]        area_ctrl [0:4];
	logic [7:0]        ctl;
	logic [3:0]        sel;
	logic [2:0]        remain;
	logic [1:0]        idx;
	logic              is_write;
	logic [3:0]        wcnt;
	logic              w1, w2, w3, wait_lvl;
	logic [3:0]        en_vec;
	logic [3:0]        hit;
	logic [3:0]        next_sel;
	logic [7:0]        next_ctl;
	logic [1:0]        lane_use;
	logic [2:0]        beat_bytes;
	logic [2:0]        wcode;
	logic              extend;
	logic              beat_end;

	// ==========================================================
	// control bytes
	genvar a;
	generate
		for (a = 0; a <= DEFAULT_AREA; a++) begin : g_ctrl
			always_ff @(posedge CLK or negedge RESETN) begin
				if (!RESETN)
					area_ctrl[a] <= (a == ENABLED_AREA) ?
						CTRL_RESET_ON : CTRL_RESET_OFF;
				else if (CTRL_WE[a])
					area_ctrl[a] <= CTRL_WDATA;
			end
			assign AREA_CONTROL_Q[a*CTRL_W +: CTRL_W] = area_ctrl[a];
		end
		for (a = 0; a < AREAS; a++) begin : g_en
			assign en_vec[a] = area_ctrl[a][ENABLE_BIT];
		end
	endgenerate

	// ==========================================================
	// area decode, lowest enabled area wins
	always_comb begin
		hit      = AREA_HIT & en_vec;
		next_sel = 4'h0;
		next_ctl = area_ctrl[DEFAULT_AREA];
		for (int i = AREAS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				next_sel    = 4'h0;
				next_sel[i] = 1'b1;
				next_ctl    = area_ctrl[i];
			end
		end
	end

	// ==========================================================
	// wait pin synchroniser
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			w1       <= 1'b1;
			w2       <= 1'b1;
			w3       <= 1'b1;
			wait_lvl <= 1'b1;
		end else begin
			w1 <= WAIT_N;
			w2 <= w1;
			w3 <= w2;
			if (w2 == w3)
				wait_lvl <= w3;
		end
	end

	// ==========================================================
	// lane plan
	cbs_lane u_lane (
		.bus8       (ctl[WIDTH_BIT]),
		.addr0      (EXT_ADDR[0]),
		.remain     (remain),
		.lane_use   (lane_use),
		.beat_bytes (beat_bytes)
	);

	assign wcode    = ctl[WAIT_LSB +: WAIT_W];
	assign extend   = (wcode == WAIT_ONE_EXT) || (wcode == WAIT_ZERO_EXT);
	assign beat_end = (state == ST_ACCESS) &&
		(wcnt >= cbs_wait_count(wcode)) &&
		(!extend || wait_lvl);

	// ==========================================================
	// sequencer
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state    <= ST_IDLE;
			ctl      <= CTRL_RESET_OFF;
			sel      <= 4'h0;
			remain   <= 3'h0;
			idx      <= 2'h0;
			is_write <= 1'b0;
			wcnt     <= CNT_0;
			EXT_ADDR <= '0;
			ACK      <= 1'b0;
		end else begin
			ACK <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (REQ) begin
						if (INTERNAL_HIT) begin
							ACK <= 1'b1;
						end else begin
							state    <= ST_SETUP;
							ctl      <= next_ctl;
							sel      <= next_sel;
							remain   <= SIZE;
							idx      <= 2'h0;
							is_write <= WRITE;
							EXT_ADDR <= ADDR;
						end
					end
				end
				ST_SETUP: begin
					state <= ST_ACCESS;
					wcnt  <= CNT_0;
				end
				ST_ACCESS: begin
					// saturate so a long pin stretch cannot wrap the count
					if (wcnt != 4'hF)
						wcnt <= wcnt + CNT_1;
					if (beat_end) begin
						if (remain == beat_bytes) begin
							state <= ST_IDLE;
							ACK   <= 1'b1;
						end else begin
							state    <= ST_SETUP;
							remain   <= remain - beat_bytes;
							idx      <= idx + beat_bytes[1:0];
							EXT_ADDR <= EXT_ADDR + ADDR_W'(beat_bytes);
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// strobes and selects
	always_comb begin
		AREA_SELECT_N = ~(sel & {4{state != ST_IDLE}});
		RD_N          = !(state == ST_ACCESS && !is_write);
		WR_N          = !(state == ST_ACCESS && is_write && lane_use[0]);
		HIGH_LANE_WRITE_STROBE_N = !(state == ST_ACCESS && is_write &&
			lane_use[1]);
	end

	// ==========================================================
	// write lanes and read capture
	genvar l, k;
	generate
		for (l = 0; l < 2; l++) begin : g_wlane
			always_ff @(posedge CLK or negedge RESETN) begin
				if (!RESETN) begin
					DATA_OUT[l*8 +: 8] <= 8'h00;
					DATA_OE[l]         <= 1'b0;
				end else if (state == ST_SETUP) begin
					DATA_OE[l] <= is_write && lane_use[l];
					DATA_OUT[l*8 +: 8] <= (beat_bytes == BYTES_2) ?
						WDATA[8*(idx + 2'(l)) +: 8] : WDATA[8*idx +: 8];
				end else if (state == ST_IDLE) begin
					DATA_OE[l] <= 1'b0;
				end
			end
		end
		for (k = 0; k < 4; k++) begin : g_rbyte
			always_ff @(posedge CLK or negedge RESETN) begin
				if (!RESETN)
					RDATA[k*8 +: 8] <= 8'h00;
				else if (state == ST_IDLE && REQ)
					RDATA[k*8 +: 8] <= 8'h00;
				else if (beat_end && !is_write) begin
					if (2'(k) == idx)
						RDATA[k*8 +: 8] <= lane_use[0] ?
							DATA_IN[7:0] : DATA_IN[15:8];
					else if (beat_bytes == BYTES_2 && 2'(k) == idx + 2'h1)
						RDATA[k*8 +: 8] <= DATA_IN[15:8];
				end
			end
		end
	endgenerate

	// ==========================================================
	// checks
	logic first;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			first <= 1'b1;
		else
			first <= 1'b0;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	property p_reset_values;
		first |-> area_ctrl[0] == CTRL_RESET_OFF &&
			area_ctrl[2] == CTRL_RESET_ON && area_ctrl[4] == CTRL_RESET_OFF;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("control bytes wrong after reset");

	property p_disabled_quiet;
		((~AREA_SELECT_N) & ~en_vec & ~$past(en_vec)) == 4'h0;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("select of disabled area active");

	property p_bus8_low_lane;
		state == ST_ACCESS && ctl[WIDTH_BIT] |-> lane_use == 2'h1;
	endproperty
	a_bus8_low_lane: assert property (p_bus8_low_lane)
		else $error("8-bit area used high lane");

	property p_unused_lane_float;
		state == ST_ACCESS && !lane_use[1] |-> !DATA_OE[1];
	endproperty
	a_unused_lane_float: assert property (p_unused_lane_float)
		else $error("unused lane driven");

	property p_unused_strobe;
		state == ST_ACCESS && !lane_use[1] |-> HIGH_LANE_WRITE_STROBE_N;
	endproperty
	a_unused_strobe: assert property (p_unused_strobe)
		else $error("unused lane strobe active");

	property p_zero_wait;
		state == ST_SETUP && wcode == WAIT_NONE |=> ##1 state != ST_ACCESS;
	endproperty
	a_zero_wait: assert property (p_zero_wait)
		else $error("zero wait cycle too long");

	property p_two_wait;
		state == ST_SETUP && wcode == WAIT_TWO |=>
			state == ST_ACCESS [*3] ##1 state != ST_ACCESS;
	endproperty
	a_two_wait: assert property (p_two_wait)
		else $error("two wait cycle wrong length");

	property p_internal;
		state == ST_IDLE && REQ && INTERNAL_HIT |=> ACK && &AREA_SELECT_N;
	endproperty
	a_internal: assert property (p_internal)
		else $error("internal access went outside");

	property p_default_area;
		state == ST_IDLE && REQ && !INTERNAL_HIT && (AREA_HIT & en_vec) == 4'h0
			|=> ctl == $past(area_ctrl[4]) && sel == 4'h0;
	endproperty
	a_default_area: assert property (p_default_area)
		else $error("default area control not used");

	c_split_read: cover property (state == ST_ACCESS && !is_write &&
		remain == 3'h4 && ctl[WIDTH_BIT]);
	c_wide_write: cover property (state == ST_ACCESS && is_write &&
		lane_use == 2'h3);
	c_wait_ext: cover property (state == ST_ACCESS && extend && !wait_lvl);
endmodule // cbs_top

`default_nettype wire

/* cbs_mem.sv */
/* far-side memory: byte store behind a 16-bit data bus.
   assumes strobes, selects and address from cbs_top on CLK. */
`timescale 1ns/1ps
`default_nettype none
module cbs_mem
	import cbs_pkg::*;
(
	// bus from block
	input  wire logic        CLK,
	input  wire logic [23:0] EXT_ADDR,
	input  wire logic [3:0]  SEL_N,
	input  wire logic        RD_N,
	input  wire logic        WR_N,
	input  wire logic        HWR_N,
	input  wire logic [15:0] DOUT,
	// bench settings
	input  wire logic [4:0]  NARROW,
	input  wire logic [3:0]  STALL,
	// answers
	output logic [15:0]      DIN,
	output logic             WAIT_N
);
	logic [7:0] mem [0:255];
	logic [7:0] pat;
	logic [7:0] a;
	logic [3:0] cnt;
	logic       nar;
	initial begin
		pat = 8'h00;
		cnt = 4'h0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
	end
	assign a = EXT_ADDR[7:0];
	assign nar = &SEL_N ? NARROW[4] : |(~SEL_N & NARROW[3:0]);
	// ======
	// store and wait
	always @(posedge CLK) begin
		pat <= pat + 8'h3B;
		cnt <= &SEL_N ? 4'h0 : cnt + 4'h1;
		if (!WR_N) mem[nar ? a : {a[7:1], 1'b0}] <= DOUT[7:0];
		if (!HWR_N) mem[{a[7:1], 1'b1}] <= DOUT[15:8];
	end
	assign WAIT_N = cnt >= STALL;
	// ======
	// read lanes, garbage where unused
	assign DIN = RD_N ? {pat, ~pat} : nar ? {pat, mem[a]} :
		{mem[{a[7:1], 1'b1}], mem[{a[7:1], 1'b0}]};
endmodule // cbs_mem
`default_nettype wire

/* chip_select_bus_sizing_tb.sv */
/* bench for cbs_top: random and corner transfers against cbs_mem.
   assumes cbs_pkg and cbs_mem compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module chip_select_bus_sizing_tb
	import cbs_pkg::*;
;
	logic        clk = 1'b0;
	logic        rstn, req, wr, ih, ack, rd_n, wr_n, hwr_n, wait_n, cur8;
	logic        busy_ih;
	logic [4:0]  we, narrow;
	logic [7:0]  wd;
	logic [39:0] ctlq;
	logic [2:0]  sz;
	logic [23:0] addr, xa;
	logic [31:0] wdat, rdat;
	logic [3:0]  hit, sel_n, stall, exp_sel;
	logic [15:0] dout, din;
	logic [1:0]  oe;
	logic [7:0]  sh [0:255];
	logic [7:0]  ctl [0:4];
	int          n_fail, num_checks, cyc, lat, seed, k;
	cbs_top uut (.CLK(clk), .RESETN(rstn), .CTRL_WE(we), .CTRL_WDATA(wd),
		.AREA_CONTROL_Q(ctlq), .REQ(req), .WRITE(wr), .SIZE(sz),
		.ADDR(addr), .WDATA(wdat), .AREA_HIT(hit), .INTERNAL_HIT(ih),
		.ACK(ack), .RDATA(rdat), .EXT_ADDR(xa), .AREA_SELECT_N(sel_n),
		.RD_N(rd_n), .WR_N(wr_n), .HIGH_LANE_WRITE_STROBE_N(hwr_n),
		.DATA_OUT(dout), .DATA_OE(oe), .DATA_IN(din), .WAIT_N(wait_n));
	cbs_mem mem (.CLK(clk), .EXT_ADDR(xa), .SEL_N(sel_n), .RD_N(rd_n),
		.WR_N(wr_n), .HWR_N(hwr_n), .DOUT(dout), .NARROW(narrow),
		.STALL(stall), .DIN(din), .WAIT_N(wait_n));
	always #2.5 clk = ~clk;
	// ======
	// expectations
	function automatic int fw(input logic [2:0] c);
		case (c)
			3'h0: return 2;
			3'h1, 3'h2: return 1;
			3'h5: return 3;
			3'h6: return 4;
			3'h7: return 8;
			default: return 0;
		endcase
	endfunction
	function automatic int nbeats(input int ad, input int s, input bit n8);
		int b = 0;
		if (n8) return s;
		while (s > 0) begin
			if (!ad[0] && s >= 2) begin
				s -= 2;
				ad += 2;
			end else begin
				s--;
				ad++;
			end
			b++;
		end
		return b;
	endfunction
	// ======
	// checking and close
	task chk(input logic [39:0] s, input logic [39:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ======
	// drivers
	task wctl(input int i, input logic [7:0] d);
		@(negedge clk);
		we = 5'(1 << i);
		wd = d;
		ctl[i] = d;
		narrow[i] = d[3];
		@(negedge clk);
		we = 5'h00;
	endtask
	task op(input bit w, input int i, input int s, input int ad,
		input bit inh);
		int eff;
		eff = (i < 4 && ctl[i][7]) ? i : 4;
		cur8 = ctl[eff][3];
		@(negedge clk);
		req = 1'b1;
		wr = w;
		sz = 3'(s);
		addr = 24'(ad);
		wdat = $random(seed);
		hit = i < 4 ? 4'(1 << i) : 4'h0;
		ih = inh;
		busy_ih = inh;
		exp_sel = (eff < 4 && !inh) ? ~4'(1 << i) : 4'hF;
		lat = 0;
		do begin
			@(negedge clk);
			req = 1'b0;
			lat++;
		end while (ack !== 1'b1 && lat < 300);
		for (int b = 0; b < s; b++)
			if (w && !inh) sh[(ad + b) & 255] = wdat[8*b +: 8];
			else if (!inh) chk(rdat[8*b +: 8], sh[(ad + b) & 255]);
		if (inh && !w) chk(rdat, 40'h0);
		if (!inh && stall == 4'h0)
			chk(lat, nbeats(ad, s, cur8) * (2 + fw(ctl[eff][2:0])) + 1);
		busy_ih = 1'b0;
	endtask
	// ======
	// bus watch and timeout
	always @(negedge clk) if (rstn) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			final_report;
		end
		if (!rd_n || !wr_n || !hwr_n) begin
			chk(sel_n, exp_sel);
			chk(busy_ih, 1'b0);
			chk(cur8 && !hwr_n, 1'b0);
			if (wr) chk(oe, {~hwr_n, ~wr_n});
		end
	end
	// ======
	// main sequence
	initial begin
		seed = 32'h71be;
		{rstn, req, wr, ih, busy_ih, cur8} = 6'h00;
		{we, narrow, wd, sz, addr, wdat, hit, stall} = '0;
		exp_sel = 4'hF;
		{n_fail, num_checks, cyc} = '0;
		for (k = 0; k < 256; k++) sh[k] = 8'(k) ^ 8'h5A;
		for (k = 0; k < 5; k++) ctl[k] = 8'h00;
		ctl[2] = 8'h80;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		chk(ctlq, 40'h0000800000);
		op(1'b1, 2, 4, 7, 1'b0);
		op(1'b0, 2, 4, 7, 1'b0);
		wctl(0, 8'h83);
		wctl(4, 8'h09);
		wctl(3, 8'h03);
		for (int c = 0; c < 8; c++) begin
			wctl(1, 8'h88 | 8'(c));
			op(c[0], 1, 1, 40 + c, 1'b0);
		end
		wctl(1, 8'h8B);
		repeat (60) begin
			k = $random(seed) & 32'h7FFFFFFF;
			op(k[12], k % 5, 1 << ((k >> 3) % 3), (k >> 5) % 252, 1'b0);
		end
		op(1'b1, 0, 2, 4, 1'b1);
		op(1'b0, 0, 2, 4, 1'b1);
		stall = 4'h6;
		for (int c = 2; c < 5; c += 2) begin
			wctl(0, 8'h80 | 8'(c));
			op(1'b0, 0, 2, 8, 1'b0);
			chk(lat > 6, 1'b1);
		end
		final_report;
	end
endmodule // chip_select_bus_sizing_tb
`default_nettype wire
